// file: hw/kpx_i2c_slave.v
`include "kpx_regs.vh"
module kpx_i2c_slave (
  // clock and power-up reset
  input  wire        ref_clk_i,
  input  wire        srst_i,
  // synchronised bus lines
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_oe_o,
  // port data
  input  wire [15:0] key_port_i,
  input  wire [15:0] en_port_i,
  output reg         en_wr_o,
  output reg  [15:0] en_wr_data_o,
  output reg         key_read_o
);

  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_WR   = 3'd3;
  localparam ST_WACK = 3'd4;
  localparam ST_RD   = 3'd5;
  localparam ST_RACK = 3'd6;

  reg [2:0]  state;
  reg [2:0]  bit_cnt;
  reg [7:0]  shreg;
  reg [15:0] rd_data;
  reg        byte_hi;
  reg        sel_key;
  reg        lo_done;
  reg [7:0]  lo_byte;
  reg        scl_d;
  reg        sda_d;
  reg        addr_armed;

  wire scl_rise = scl_i & ~scl_d;
  wire scl_fall = ~scl_i & scl_d;
  wire start    = scl_i & scl_d & sda_d & ~sda_i;
  wire stop     = scl_i & scl_d & ~sda_d & sda_i;
  wire [7:0] rd_byte = byte_hi ? rd_data[15:8] : rd_data[7:0];

  always @(posedge ref_clk_i) begin
    scl_d <= scl_i;
    sda_d <= sda_i;
    en_wr_o <= 1'b0;
    key_read_o <= 1'b0;
    if (srst_i) begin
      state <= ST_IDLE;
      sda_oe_o <= 1'b0;
      bit_cnt <= 3'd0;
      shreg <= 8'h00;
      rd_data <= 16'h0000;
      byte_hi <= 1'b0;
      sel_key <= 1'b0;
      lo_done <= 1'b0;
      lo_byte <= 8'h00;
      en_wr_data_o <= 16'h0000;
      addr_armed <= 1'b0;
    end else if (start) begin
      state <= ST_ADDR;
      bit_cnt <= 3'd0;
      addr_armed <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (stop) begin
      state <= ST_IDLE;
      sda_oe_o <= 1'b0;
      // read over: clear the change flag
      if (sel_key && byte_hi)
        key_read_o <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          sda_oe_o <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_i};
            bit_cnt <= bit_cnt + 3'd1;
            addr_armed <= 1'b1;
          end
          // skip the fall that closes the start condition
          if (scl_fall && bit_cnt == 3'd0 && addr_armed) begin
            addr_armed <= 1'b0;
            byte_hi <= 1'b0;
            lo_done <= 1'b0;
            if (shreg == `KPX_KEYPAD_RD_ADDR || shreg == `KPX_ENABLE_RD_ADDR ||
                shreg == `KPX_ENABLE_WR_ADDR) begin
              sel_key <= (shreg == `KPX_KEYPAD_RD_ADDR);
              rd_data <= (shreg == `KPX_KEYPAD_RD_ADDR) ? key_port_i : en_port_i;
              sda_oe_o <= 1'b1;
              state <= ST_AACK;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (shreg[0]) begin
              sda_oe_o <= ~rd_byte[7];
              shreg <= {rd_byte[6:0], 1'b1};
              state <= ST_RD;
            end else begin
              sda_oe_o <= 1'b0;
              state <= ST_WR;
            end
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_i};
            bit_cnt <= bit_cnt + 3'd1;
          end
          if (scl_fall && bit_cnt == 3'd0) begin
            sda_oe_o <= 1'b1;
            state <= ST_WACK;
            if (!lo_done) begin
              lo_byte <= shreg;
              lo_done <= 1'b1;
            end else begin
              en_wr_data_o <= {shreg, lo_byte};
              en_wr_o <= 1'b1;
              lo_done <= 1'b0;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            sda_oe_o <= 1'b0;
            state <= ST_WR;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            bit_cnt <= bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
              sda_oe_o <= 1'b0;
              state <= ST_RACK;
            end else begin
              sda_oe_o <= ~shreg[7];
              shreg <= {shreg[6:0], 1'b1};
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_i) begin
              state <= ST_IDLE;
            end else begin
              if (byte_hi)
                rd_data <= sel_key ? key_port_i : en_port_i;
              byte_hi <= ~byte_hi;
            end
          end
          if (scl_fall && state == ST_RACK) begin
            sda_oe_o <= ~rd_byte[7];
            shreg <= {rd_byte[6:0], 1'b1};
            bit_cnt <= 3'd0;
            state <= ST_RD;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // kpx_i2c_slave

// file: hw/kpx_regs.vh
`ifndef KPX_REGS_VH
`define KPX_REGS_VH
// 8-bit address bytes (7-bit address plus read/write bit)
`define KPX_KEYPAD_RD_ADDR    8'h49
`define KPX_ENABLE_WR_ADDR    8'h44
`define KPX_ENABLE_RD_ADDR    8'h45
`define KPX_PORT_WIDTH        16
`define KPX_PORT_RESET        16'hFFFF
`define KPX_CARD_WP_BIT       8
`define KPX_CARD_CD_BIT       9
`define KPX_SERIAL_A_BIT      0
`define KPX_SERIAL_B_BIT      1
`define KPX_INFRARED_BIT      2
`define KPX_DISPLAY_BIT       3
`define KPX_RADIO_BIT         4
`define KPX_CARD_SPI_BIT      5
`endif

// file: hw/kpx_sync.v
module kpx_sync #(
  parameter WIDTH = 1
) (
  // clock
  input  wire             ref_clk_i,
  // data
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;

  always @(posedge ref_clk_i) begin
    stage1 <= async_i;
    sync_o <= stage1;
  end

endmodule // kpx_sync

// file: hw/kpx_top.v
// Overview of operation
// - keypad expander reads at address 0x49, returning all sixteen key levels
// - keypad interrupt raised on any key press or release
// - pressed key reads zero, released key reads one
// - keys 0-7 on low byte, keys 8-15 on high byte, ascending
// - enable expander writes at 0x44, reads at 0x45
// - each expander one 16-bit quasi-bidirectional port, reached only over I2C
// - power-up puts every pin in input mode (latched high)
// - system reset leaves expander state and outputs unchanged
// - enable low byte: serial a, serial b, infrared, display, radio, card spi
// - enable high byte pin 0 write protect, pin 1 card detect
// - forcing switch keeps peripheral enabled regardless of software bit
`include "kpx_regs.vh"
module kpx_top #(
  parameter WIDTH = `KPX_PORT_WIDTH
) (
  // clock and resets
  input  wire             ref_clk_i,
  input  wire             srst_i,
  input  wire             power_on_rst_i,
  // i2c bus
  input  wire             scl_i,
  input  wire             sda_i,
  output reg              sda_o,
  output reg              sda_oe_o,
  // keypad pins, low when pressed
  input  wire [WIDTH-1:0] key_pins_i,
  output reg              keypad_irq_input_pin_o,
  // board enable switches, high forces enable
  input  wire             force_serial_a_i,
  input  wire             force_serial_b_i,
  input  wire             force_infrared_i,
  input  wire             force_display_i,
  // card status pins
  input  wire             card_write_protect_i,
  input  wire             card_detect_i,
  // peripheral enables, active low
  output reg              serial_a_xcvr_enable_n_o,
  output reg              serial_b_xcvr_enable_n_o,
  output reg              infrared_enable_n_o,
  output reg              display_power_enable_n_o,
  output reg              radio_module_enable_n_o,
  output reg              card_spi_path_enable_o
);

  // =====================================================
  // input synchronisers
  // =====================================================
  wire [WIDTH-1:0] key_sync;
  wire [7:0]       misc_sync;

  kpx_sync #(.WIDTH(WIDTH)) u_key_sync (
    .ref_clk_i (ref_clk_i),
    .async_i   (key_pins_i),
    .sync_o    (key_sync)
  );

  kpx_sync #(.WIDTH(8)) u_misc_sync (
    .ref_clk_i (ref_clk_i),
    .async_i   ({scl_i, sda_i, force_serial_a_i, force_serial_b_i, force_infrared_i,
                 force_display_i, card_write_protect_i, card_detect_i}),
    .sync_o    (misc_sync)
  );

  wire scl_s   = misc_sync[7];
  wire sda_s   = misc_sync[6];
  wire frc_a   = misc_sync[5];
  wire frc_b   = misc_sync[4];
  wire frc_ir  = misc_sync[3];
  wire frc_dsp = misc_sync[2];
  wire wp_s    = misc_sync[1];
  wire cd_s    = misc_sync[0];

  // =====================================================
  // port latches
  // =====================================================
  reg  [WIDTH-1:0] en_latch;
  reg  [WIDTH-1:0] key_snap;
  wire             en_wr;
  wire [15:0]      en_wr_data;
  wire             key_read;
  wire             slave_oe;
  wire [WIDTH-1:0] en_port_pins;
  wire [WIDTH-1:0] key_port;

  // pin i is key i, low when pressed
  assign key_port = key_sync;

  // quasi-bidirectional: a pin reads low if latched low
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_qb
      wire ext_level;
      if (i == `KPX_CARD_WP_BIT) begin : g_wp
        assign ext_level = wp_s;
      end else if (i == `KPX_CARD_CD_BIT) begin : g_cd
        assign ext_level = cd_s;
      end else begin : g_nc
        assign ext_level = 1'b1;
      end
      assign en_port_pins[i] = en_latch[i] & ext_level;
    end
  endgenerate

  always @(posedge ref_clk_i) begin
    if (power_on_rst_i) begin
      en_latch <= `KPX_PORT_RESET;
    end else if (en_wr) begin
      en_latch <= en_wr_data;
    end
  end

  // =====================================================
  // keypad change interrupt
  // =====================================================
  // flag any difference from last read snapshot
  always @(posedge ref_clk_i) begin
    if (power_on_rst_i) begin
      key_snap <= `KPX_PORT_RESET;
      keypad_irq_input_pin_o <= 1'b1;
    end else begin
      if (key_read)
        key_snap <= key_port;
      keypad_irq_input_pin_o <= (key_read ? 1'b1 : ~(|(key_port ^ key_snap)));
    end
  end

  // =====================================================
  // i2c slave
  // =====================================================
  // port reached only over i2c
  kpx_i2c_slave u_slave (
    .ref_clk_i    (ref_clk_i),
    .srst_i       (power_on_rst_i),
    .scl_i        (scl_s),
    .sda_i        (sda_s),
    .sda_oe_o     (slave_oe),
    .key_port_i   (key_port),
    .en_port_i    (en_port_pins),
    .en_wr_o      (en_wr),
    .en_wr_data_o (en_wr_data),
    .key_read_o   (key_read)
  );

  // =====================================================
  // outputs
  // =====================================================
  always @(posedge ref_clk_i) begin
    sda_o <= 1'b0;
    if (power_on_rst_i) begin
      sda_oe_o                 <= 1'b0;
      serial_a_xcvr_enable_n_o <= 1'b1;
      serial_b_xcvr_enable_n_o <= 1'b1;
      infrared_enable_n_o      <= 1'b1;
      display_power_enable_n_o <= 1'b1;
      radio_module_enable_n_o  <= 1'b1;
      card_spi_path_enable_o   <= 1'b1;
    end else begin
      sda_oe_o <= slave_oe;
      serial_a_xcvr_enable_n_o <= en_latch[`KPX_SERIAL_A_BIT] & ~frc_a;
      serial_b_xcvr_enable_n_o <= en_latch[`KPX_SERIAL_B_BIT] & ~frc_b;
      infrared_enable_n_o      <= en_latch[`KPX_INFRARED_BIT] & ~frc_ir;
      display_power_enable_n_o <= en_latch[`KPX_DISPLAY_BIT] & ~frc_dsp;
      radio_module_enable_n_o  <= en_latch[`KPX_RADIO_BIT];
      card_spi_path_enable_o   <= en_latch[`KPX_CARD_SPI_BIT];
    end
  end

endmodule // kpx_top

// file: test/i2c_host_model.sv
module i2c_host_model (
  // bus lines
  output logic scl_o,
  output logic sda_low_o,
  input  wire  sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HP = 320;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // data changes only mid low phase
  task automatic bit_cycle(input logic b, output logic s);
    #(HP/2) sda_low_o = !b;
    #(HP/2) scl_o = 1'b1;
    #(HP/2) s = sda_i;
    #(HP/2) scl_o = 1'b0;
  endtask
  task automatic start_c();
    sda_low_o = 1'b1;
    #HP scl_o = 1'b0;
  endtask
  task automatic stop_c();
    #(HP/2) sda_low_o = 1'b1;
    #(HP/2) scl_o = 1'b1;
    #HP sda_low_o = 1'b0;
    #HP;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_cycle(tx[i], rx[i]);
    bit_cycle(ack_in, ack_out);
  endtask
endmodule // i2c_host_model

// file: test/kpx_top_monitor.sv
module kpx_top_monitor (
  // clock and reset
  input wire ref_clk_i,
  input wire power_on_rst_i,
  // bus and interrupt
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire keypad_irq_input_pin_o,
  // switches
  input wire force_serial_a_i,
  input wire force_serial_b_i,
  input wire force_infrared_i,
  input wire force_display_i,
  // enables
  input wire serial_a_xcvr_enable_n_o,
  input wire serial_b_xcvr_enable_n_o,
  input wire infrared_enable_n_o,
  input wire display_power_enable_n_o,
  input wire radio_module_enable_n_o,
  input wire card_spi_path_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [5:0] en_n = {card_spi_path_enable_o, radio_module_enable_n_o, display_power_enable_n_o,
                     infrared_enable_n_o, serial_b_xcvr_enable_n_o, serial_a_xcvr_enable_n_o};
  default clocking cb @(posedge ref_clk_i);
  endclocking
  // ====================
  // sequences
  sequence scl_settled;
    scl_i [*6];
  endsequence
  sequence held(f);
    (f && !power_on_rst_i) [*4];
  endsequence
  // ====================
  // power-up state, sda drive and forcing switches
  a_reset_enables_off: assert property (power_on_rst_i |=> en_n == 6'h3F) else $error("enables on");
  a_reset_sda_free: assert property (power_on_rst_i |=> !sda_oe_o) else $error("sda driven");
  a_reset_irq_idle: assert property (power_on_rst_i |=> keypad_irq_input_pin_o) else $error("irq low");
  a_sda_pull_low: assert property (disable iff (power_on_rst_i) sda_o == 1'b0) else $error("sda high");
  a_force_serial_a: assert property (held(force_serial_a_i) |-> !en_n[0]) else $error("serial a off");
  a_force_serial_b: assert property (held(force_serial_b_i) |-> !en_n[1]) else $error("serial b off");
  a_force_infra_red: assert property (held(force_infrared_i) |-> !en_n[2]) else $error("infrared off");
  a_force_display_on: assert property (held(force_display_i) |-> !en_n[3]) else $error("display off");
  a_oe_scl_high: assert property (disable iff (power_on_rst_i) scl_settled |-> $stable(sda_oe_o))
    else $error("sda moved");
  // radio and card spi enables change only by bus write
  a_idle_outputs_hold: assert property (disable iff (power_on_rst_i) scl_settled |-> $stable(en_n[5:4]))
    else $error("enable moved");
endmodule // kpx_top_monitor
bind kpx_top kpx_top_monitor i_kpx_top_monitor (.ref_clk_i, .power_on_rst_i, .scl_i, .sda_o, .sda_oe_o,
  .keypad_irq_input_pin_o, .force_serial_a_i, .force_serial_b_i, .force_infrared_i, .force_display_i,
  .serial_a_xcvr_enable_n_o, .serial_b_xcvr_enable_n_o, .infrared_enable_n_o, .display_power_enable_n_o,
  .radio_module_enable_n_o, .card_spi_path_enable_o);

// file: test/kpx_top_tb_top.sv
`include "kpx_regs.vh"
module kpx_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, srst, por_rst, wp, cd;
  logic [15:0] keys;
  logic [3:0]  force_sw;
  wire         scl, host_low, sda_oe, irq_n;
  wire  [5:0]  en_seen;
  wire         sda_line = !(host_low || sda_oe);
  int          failures, comparisons;
  kpx_top i_kpx_top (.ref_clk_i(ref_clk), .srst_i(srst), .power_on_rst_i(por_rst), .scl_i(scl),
    .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe), .key_pins_i(keys), .keypad_irq_input_pin_o(irq_n),
    .force_serial_a_i(force_sw[0]), .force_serial_b_i(force_sw[1]), .force_infrared_i(force_sw[2]),
    .force_display_i(force_sw[3]), .card_write_protect_i(wp), .card_detect_i(cd),
    .serial_a_xcvr_enable_n_o(en_seen[0]), .serial_b_xcvr_enable_n_o(en_seen[1]),
    .infrared_enable_n_o(en_seen[2]), .display_power_enable_n_o(en_seen[3]),
    .radio_module_enable_n_o(en_seen[4]), .card_spi_path_enable_o(en_seen[5]));
  i2c_host_model i_i2c_host_model (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda_line));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ====================
  // helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] exp_en(input logic [15:0] l, input logic [3:0] f);
    return {10'h000, l[5:0] & ~{2'b00, f}};
  endfunction
  task automatic xact(input logic [7:0] addr, input logic [15:0] wd, output logic [15:0] rd, output logic a);
    logic [7:0] rx;
    logic       d;
    i_i2c_host_model.start_c();
    i_i2c_host_model.xfer(addr, 1'b1, rx, a);
    i_i2c_host_model.xfer(wd[7:0], !addr[0], rd[7:0], d);
    i_i2c_host_model.xfer(wd[15:8], 1'b1, rd[15:8], d);
    i_i2c_host_model.stop_c();
  endtask
  task automatic wrap_up();
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ====================
  // tests
  initial begin
    logic [15:0] latch, got;
    logic        a;
    {srst, por_rst, wp, cd, keys, force_sw} = {4'hC, 16'hFFFF, 4'h0};
    failures = 0;
    comparisons = 0;
    void'($urandom(84));
    repeat (4) @(negedge ref_clk);
    {srst, por_rst} = 2'b00;
    repeat (6) @(negedge ref_clk);
    chk("enables_reset", 16'h003F, {10'h000, en_seen});
    chk("irq_reset", 16'h0001, {15'h0000, irq_n});
    for (int i = 0; i < 5; i++) begin
      latch = {8'hFF, (i == 0) ? 8'h04 : 8'($urandom())};
      force_sw = (i == 0) ? 4'h0 : 4'($urandom());
      // serial b and infrared never both on
      if ((!latch[1] || force_sw[1]) && (!latch[2] || force_sw[2])) {latch[1], force_sw[1]} = 2'b10;
      {wp, cd} = 2'($urandom());
      xact(`KPX_ENABLE_WR_ADDR, latch, got, a);
      chk("write_ack", 16'h0000, {15'h0000, a});
      repeat (4) @(negedge ref_clk);
      chk("enables", exp_en(latch, force_sw), {10'h000, en_seen});
      xact(`KPX_ENABLE_RD_ADDR, 16'hFFFF, got, a);
      chk("enable_port", latch & {6'h3F, cd, wp, 8'hFF}, got);
      chk("read_ack", 16'h0000, {15'h0000, a});
      srst = 1'b1;
      @(negedge ref_clk);
      srst = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk("enables_srst", exp_en(latch, force_sw), {10'h000, en_seen});
    end
    for (int i = 0; i < 6; i++) begin
      keys = (i % 2) ? 16'hFFFF : ((i == 0) ? 16'h7FFE : 16'($urandom()));
      if (i % 2 == 0 && keys == 16'hFFFF) keys = 16'hFFFE;
      repeat (8) @(negedge ref_clk);
      chk("irq_change", 16'h0000, {15'h0000, irq_n});
      xact(`KPX_KEYPAD_RD_ADDR, 16'hFFFF, got, a);
      chk("key_levels", keys, got);
      chk("key_ack", 16'h0000, {15'h0000, a});
      repeat (4) @(negedge ref_clk);
      chk("irq_clear", 16'h0001, {15'h0000, irq_n});
    end
    // keys leave and return to the last read state
    keys = 16'hFFFD;
    repeat (8) @(negedge ref_clk);
    chk("irq_away", 16'h0000, {15'h0000, irq_n});
    keys = 16'hFFFF;
    repeat (8) @(negedge ref_clk);
    chk("irq_return", 16'h0001, {15'h0000, irq_n});
    for (int j = 0; j < 2; j++) begin
      xact(j ? 8'h48 : 8'h46, 16'h0000, got, a);
      chk("refused_ack", 16'h0001, {15'h0000, a});
    end
    wrap_up();
  end
  initial begin
    #1_000_000;
    failures++;
    wrap_up();
  end
endmodule // kpx_top_tb_top
